// [hdl/sact_map.svh]
// register map and timing constants for the switch advanced control tail
// assumes a 200 MHz system clock and an index-addressed register map
`ifndef SACT_MAP_SVH
`define SACT_MAP_SVH

// register indexes (byte address is four times the index)
`define SACT_IDX_TEST_ONE      8'hbf
`define SACT_IDX_RSVD_CTRL     8'hcf
`define SACT_IDX_TEST_TWO      8'hdf
`define SACT_IDX_P3_MEDIA      8'hef
`define SACT_IDX_TEST_THREE    8'hff
`define SACT_IDX_QUEUE_CTRL    8'hf0
`define SACT_IDX_TOP_RATE      8'hf1

// fixed read values of test registers one and two and the reserved register
`define SACT_RST_TEST_ONE      8'h80
`define SACT_RST_RSVD_CTRL     8'h15
`define SACT_RST_TEST_TWO      8'h0c

// field positions
`define SACT_BIT_FIBER         7
`define SACT_BIT_RXC_INV       4
`define SACT_BIT_PRIO_OK       7
`define SACT_QMODE_HI          1
`define SACT_QMODE_LO          0
`define SACT_RATE_HI           6
`define SACT_RATE_LO           0

// reset values of the writable fields
`define SACT_RST_FIBER         1'b0
`define SACT_RST_RXC_INV       1'b0
`define SACT_RST_RATE          7'h00

// bus geometry
`define SACT_ADDR_W            10
`define SACT_DATA_W            32
`define SACT_REG_W             8

// receive clock timing
`define SACT_CLK_MHZ           200
`define SACT_RXC_SHIFT_NS      10
`define SACT_RXC_SHIFT_CYC     ((`SACT_RXC_SHIFT_NS * `SACT_CLK_MHZ) / 1000)

`endif

// [hdl/sact_pkg.sv]
// types shared by the switch advanced control tail
// assumes sact_map.svh supplies the numeric constants
package sact_pkg;

  // egress queue arrangement of a port
  typedef enum logic [1:0] {
    SACT_Q_SINGLE,
    SACT_Q_TWO,
    SACT_Q_FOUR,
    SACT_Q_RSVD
  } sact_qmode_e;

  // bus answer state
  typedef enum logic {
    SACT_BUS_IDLE,
    SACT_BUS_ACK
  } sact_bus_e;

  // configuration that software writes
  typedef struct packed {
    logic        fiber;
    logic        rxc_inv;
    sact_qmode_e qmode;
    logic [6:0]  top_rate;
  } sact_cfg_s;

  // egress priority result
  typedef struct packed {
    logic [1:0] top_queue;
    logic [6:0] top_rate;
    logic       ratio_shaped;
  } sact_prio_s;

  // true when a port mode allows per-priority egress limiting
  function automatic logic sact_multi_queue(input sact_qmode_e m);
    return (m == SACT_Q_TWO) || (m == SACT_Q_FOUR);
  endfunction

  // highest egress queue index for a mode
  function automatic logic [1:0] sact_top_queue(input sact_qmode_e m);
    case (m)
      SACT_Q_FOUR: return 2'h3;
      SACT_Q_TWO:  return 2'h1;
      default:     return 2'h0;
    endcase
  endfunction

endpackage

// [hdl/sact_rxclk_gen.sv]
// reduced-mii receive clock generator for port 5
// assumes a 200 MHz clock; output is one quarter of it
`timescale 1ns/1ps
`include "sact_map.svh"

module sact_rxclk_gen
  import sact_pkg::*;
(
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  // control
  input  wire logic invert_i,
  // clock out
  output logic      rx_clk_o
);

  localparam int unsigned PHASE_W = 2;

  logic [PHASE_W-1:0] phase_r;   // free running divider
  logic [PHASE_W-1:0] phase_nxt; // next divider value
  logic               rx_clk_r;  // registered clock pin

  assign phase_nxt = phase_r + 2'h1;

  // divider advances every enabled cycle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase_r <= 2'h0;
    end else if (ce_i) begin
      phase_r <= phase_nxt;
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rx_clk_r <= 1'b0;
    end else if (ce_i) begin
      rx_clk_r <= phase_nxt[PHASE_W-1] ^ invert_i;
    end
  end

  assign rx_clk_o = rx_clk_r;

endmodule // sact_rxclk_gen

// [hdl/sact_queue_prio.sv]
// egress queue priority selection for rate limiting
// assumes mode and rate come from the register bank
`timescale 1ns/1ps
`include "sact_map.svh"

module sact_queue_prio
  import sact_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        ce_i,
  // configuration
  input  wire sact_qmode_e qmode_i,
  input  wire logic [6:0]  rate_i,
  // result
  output sact_prio_s       prio_o
);

  sact_prio_s prio_r; // registered result

  // queue 3 tops in four queues
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      prio_r <= '0;
    end else if (ce_i) begin
      prio_r.top_queue    <= sact_top_queue(qmode_i);
      prio_r.top_rate     <= rate_i;
      prio_r.ratio_shaped <= sact_multi_queue(qmode_i);
    end
  end

  assign prio_o = prio_r;

endmodule // sact_queue_prio

// [hdl/sact_top.sv]
// register bank for the switch advanced control tail, avalon-mm slave
// assumes a single 200 MHz clock and a master that holds requests
`timescale 1ns/1ps
`include "sact_map.svh"

module sact_top
  import sact_pkg::*;
#(
  parameter bit HAS_RMII_OPTION = 1'b1
)
(
  // clock, reset and enable
  input  wire logic                    sys_clk_i,
  input  wire logic                    resetn_i,
  input  wire logic                    ce_i,
  // avalon-mm slave
  input  wire logic [`SACT_ADDR_W-1:0] avs_address_i,
  input  wire logic                    avs_read_i,
  input  wire logic                    avs_write_i,
  input  wire logic [`SACT_DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]              avs_byteenable_i,
  output logic      [`SACT_DATA_W-1:0] avs_readdata_o,
  output logic                         avs_waitrequest_o,
  // port 5 reduced-mii
  input  wire logic                    port5_switch_reduced_mii_i,
  output logic                         switch_port_rx_clock_out_o,
  // port 3 media
  output logic                         port3_fiber_o,
  // egress priority
  output logic [1:0]                   top_queue_o,
  output logic [6:0]                   top_rate_o,
  output logic                         ratio_shaped_o
);

  localparam int unsigned IDX_W = `SACT_REG_W;

  sact_bus_e                  bus_st_r;     // answer state
  logic                       waitreq_r;    // registered waitrequest
  logic [`SACT_DATA_W-1:0]    rdata_r;      // registered read data
  logic [`SACT_DATA_W-1:0]    rdata_nxt;    // decoded read value
  sact_cfg_s                  cfg_r;        // software configuration, packed view
  logic                       fiber_cfg_r;  // port 3 media field
  logic                       rxc_inv_r;    // rx clock invert field
  sact_qmode_e                qmode_r;      // queue arrangement field
  logic [6:0]                 top_rate_r;   // top queue rate field
  sact_prio_s                 prio_w;       // priority block result
  logic                       fiber_r;      // port 3 media pin
  logic                       rxc_invert;   // effective clock inversion
  logic                       req;          // any request present
  logic                       commit;       // answer edge
  logic                       wr_commit;    // write takes effect
  logic                       lane0;        // low byte written
  logic [IDX_W-1:0]           idx;          // register index
  logic                       aligned;      // word aligned access
  logic [`SACT_REG_W-1:0]     wbyte;        // low write byte

  assign req       = avs_read_i | avs_write_i;
  assign commit    = req & ~waitreq_r;
  assign wr_commit = commit & avs_write_i;
  assign lane0     = avs_byteenable_i[0];
  assign idx       = avs_address_i[`SACT_ADDR_W-1:2];
  assign aligned   = (avs_address_i[1:0] == 2'h0);
  assign wbyte     = avs_writedata_i[`SACT_REG_W-1:0];

  // packed view of the configuration fields, each field has one writer
  assign cfg_r = '{fiber: fiber_cfg_r, rxc_inv: rxc_inv_r, qmode: qmode_r, top_rate: top_rate_r};

  assign rxc_invert = cfg_r.rxc_inv & port5_switch_reduced_mii_i;

  // answer state: one wait cycle, then waitrequest low for one edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      bus_st_r <= SACT_BUS_IDLE;
    end else if (ce_i) begin
      unique case (bus_st_r)
        // request seen: answer next cycle
        SACT_BUS_IDLE: begin
          if (req) begin
            bus_st_r <= SACT_BUS_ACK;
          end
        end
        // answer given at this edge
        SACT_BUS_ACK: begin
          bus_st_r <= SACT_BUS_IDLE;
        end
      endcase
    end
  end

  // waitrequest from its own flop, high while idle
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      waitreq_r <= 1'b1;
    end else if (ce_i) begin
      waitreq_r <= !(bus_st_r == SACT_BUS_IDLE && req);
    end
  end

  // read decode, unmapped and reserved bits read zero
  // fixed read values
  always_comb begin
    rdata_nxt = '0;
    if (aligned) begin
      unique case (idx)
        `SACT_IDX_TEST_ONE:   rdata_nxt[`SACT_REG_W-1:0] = `SACT_RST_TEST_ONE;
        `SACT_IDX_RSVD_CTRL:  rdata_nxt[`SACT_REG_W-1:0] = `SACT_RST_RSVD_CTRL;
        `SACT_IDX_TEST_TWO:   rdata_nxt[`SACT_REG_W-1:0] = `SACT_RST_TEST_TWO;
        `SACT_IDX_P3_MEDIA:   rdata_nxt[`SACT_BIT_FIBER] = cfg_r.fiber;
        `SACT_IDX_TEST_THREE: rdata_nxt[`SACT_BIT_RXC_INV] = cfg_r.rxc_inv;
        `SACT_IDX_QUEUE_CTRL: begin
          rdata_nxt[`SACT_QMODE_HI:`SACT_QMODE_LO] = cfg_r.qmode;
          rdata_nxt[`SACT_BIT_PRIO_OK]             = sact_multi_queue(cfg_r.qmode);
        end
        `SACT_IDX_TOP_RATE:   rdata_nxt[`SACT_RATE_HI:`SACT_RATE_LO] = cfg_r.top_rate;
        default:              rdata_nxt = '0;
      endcase
    end
  end

  // read data registered in the wait cycle, stands at the answer edge
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_r <= '0;
    end else if (ce_i) begin
      if (bus_st_r == SACT_BUS_IDLE && avs_read_i) begin
        rdata_r <= rdata_nxt;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fiber_cfg_r <= `SACT_RST_FIBER;
    end else if (ce_i) begin
      if (wr_commit && lane0 && aligned && idx == `SACT_IDX_P3_MEDIA) begin
        fiber_cfg_r <= wbyte[`SACT_BIT_FIBER];
      end
    end
  end

  // bit held zero without reduced-mii option
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rxc_inv_r <= `SACT_RST_RXC_INV;
    end else if (ce_i) begin
      if (HAS_RMII_OPTION && wr_commit && lane0 && aligned && idx == `SACT_IDX_TEST_THREE) begin
        rxc_inv_r <= wbyte[`SACT_BIT_RXC_INV];
      end
    end
  end

  // queue arrangement and top-queue rate
  // software-set multi queue mode
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      qmode_r    <= SACT_Q_SINGLE;
      top_rate_r <= `SACT_RST_RATE;
    end else if (ce_i) begin
      if (wr_commit && lane0 && aligned && idx == `SACT_IDX_QUEUE_CTRL) begin
        qmode_r <= sact_qmode_e'(wbyte[`SACT_QMODE_HI:`SACT_QMODE_LO]);
      end
      if (wr_commit && lane0 && aligned && idx == `SACT_IDX_TOP_RATE) begin
        top_rate_r <= wbyte[`SACT_RATE_HI:`SACT_RATE_LO];
      end
    end
  end

  // port 3 media pin registered
  always_ff @(posedge sys_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      fiber_r <= `SACT_RST_FIBER;
    end else if (ce_i) begin
      fiber_r <= cfg_r.fiber;
    end
  end

  // receive clock generator for port 5
  sact_rxclk_gen u_rxclk (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .invert_i  (rxc_invert),
    .rx_clk_o  (switch_port_rx_clock_out_o)
  );

  // egress priority selection
  sact_queue_prio u_prio (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .ce_i      (ce_i),
    .qmode_i   (cfg_r.qmode),
    .rate_i    (cfg_r.top_rate),
    .prio_o    (prio_w)
  );

  // outputs
  assign avs_readdata_o    = rdata_r;
  assign avs_waitrequest_o = waitreq_r;
  assign port3_fiber_o     = fiber_r;
  assign top_queue_o       = prio_w.top_queue;
  assign top_rate_o        = prio_w.top_rate;
  assign ratio_shaped_o    = prio_w.ratio_shaped;

  // assertions on what the bank drives
  localparam int ACK_MAX = 2;

  // read of a fixed register returns its value at the answer edge
  a_test_one_read: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && avs_read_i && !avs_waitrequest_o && $past(ce_i) && aligned && idx == `SACT_IDX_TEST_ONE)
    |-> (avs_readdata_o == {24'h000000, `SACT_RST_TEST_ONE}))
    else $error("testing register one read wrong value");

  // writes never change the reserved control read value
  a_rsvd_ctrl_fixed: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && avs_read_i && !avs_waitrequest_o && $past(ce_i) && aligned && idx == `SACT_IDX_RSVD_CTRL)
    |-> (avs_readdata_o[7:0] == `SACT_RST_RSVD_CTRL))
    else $error("reserved control read wrong value");

  // a request is answered within a bounded wait
  a_bus_answers: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && $rose(avs_read_i | avs_write_i)) ##1 ce_i |-> ##[0:ACK_MAX] !avs_waitrequest_o)
    else $error("waitrequest never released");

  // media write reaches the port 3 pin two cycles later
  a_media_select: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (wr_commit && ce_i && lane0 && aligned && idx == `SACT_IDX_P3_MEDIA) ##1 ce_i ##1 ce_i
    |-> (port3_fiber_o == $past(wbyte[`SACT_BIT_FIBER], 2)))
    else $error("port 3 media pin does not follow write");

  // clock output shifted by half a period when inverted
  a_rxc_invert: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && $past(ce_i) && $stable(rxc_invert) && $past(rxc_invert))
    |-> (switch_port_rx_clock_out_o == !u_rxclk.phase_r[1]))
    else $error("receive clock not inverted");

  // without the option the invert bit stays zero
  a_rxc_reserved: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !HAS_RMII_OPTION |-> !cfg_r.rxc_inv)
    else $error("invert bit set on a part without the option");

  // four queues ranks queue 3 highest
  a_four_top_q3: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && cfg_r.qmode == SACT_Q_FOUR) ##1 ce_i |-> (top_queue_o == 2'h3))
    else $error("queue 3 not highest in four queues mode");

  // top queue gets the exact rate, lower ones ratio shaped
  a_exact_rate: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    ce_i |=> !ce_i or ((top_rate_o == $past(cfg_r.top_rate))
             && (ratio_shaped_o == sact_multi_queue($past(cfg_r.qmode)))))
    else $error("top queue rate or ratio flag wrong");

  // normal phase follows the divider when not inverted
  a_rxc_normal: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && $past(ce_i) && $stable(rxc_invert) && !$past(rxc_invert))
    |-> (switch_port_rx_clock_out_o == u_rxclk.phase_r[1]))
    else $error("receive clock phase not normal");

  // waitrequest is low for a single cycle per answer
  a_wait_one_cycle: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && !avs_waitrequest_o) |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");

  // clock enable low freezes the pins
  a_ce_freeze: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    !ce_i |=> ($stable(switch_port_rx_clock_out_o) && $stable(port3_fiber_o)
               && $stable(avs_waitrequest_o) && $stable(top_rate_o)))
    else $error("state changed while clock enable low");

  // only the low byte of read data carries a register
  a_rdata_upper: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    avs_readdata_o[`SACT_DATA_W-1:`SACT_REG_W] == 24'h000000)
    else $error("read data upper bytes not zero");

  // two queues ranks queue 1 highest
  a_two_top_q1: assert property (
    @(posedge sys_clk_i) disable iff (!resetn_i)
    (ce_i && cfg_r.qmode == SACT_Q_TWO) ##1 ce_i |-> (top_queue_o == 2'h1))
    else $error("queue 1 not highest in two queues mode");

  // main scenarios
  c_media_fiber: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(port3_fiber_o));
  c_rxc_invert:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $rose(rxc_invert));
  c_four_queues: cover property (@(posedge sys_clk_i) disable iff (!resetn_i) top_queue_o == 2'h3);
  c_ce_pause:    cover property (@(posedge sys_clk_i) disable iff (!resetn_i) $fell(ce_i));
  c_back_to_bk:  cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
                                 commit ##1 (req && waitreq_r));

endmodule // sact_top

// [testbench/sact_host_model.sv]
// host-side avalon-mm master model for the switch advanced control tail
// assumes a slave that drops waitrequest for one cycle to answer
`timescale 1ns/1ps
`include "sact_map.svh"

module sact_host_model (
  // clock
  input  wire logic                    sys_clk_i,
  // slave answer
  input  wire logic                    avs_waitrequest_i,
  input  wire logic [`SACT_DATA_W-1:0] avs_readdata_i,
  // master request
  output logic      [`SACT_ADDR_W-1:0] avs_address_o,
  output logic                         avs_read_o,
  output logic                         avs_write_o,
  output logic      [`SACT_DATA_W-1:0] avs_writedata_o,
  output logic      [3:0]              avs_byteenable_o
);
  // idle bus from time zero
  initial begin
    avs_address_o    = '1;
    avs_read_o       = 1'b0;
    avs_write_o      = 1'b0;
    avs_writedata_o  = '1;
    avs_byteenable_o = 4'h0;
  end

  // one transfer: raise after an edge, hold until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [9:0] a, input logic [31:0] d,
                      input logic [3:0] be, output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address_o    <= a;
    avs_write_o      <= wr;
    avs_read_o       <= !wr;
    avs_writedata_o  <= d;
    avs_byteenable_o <= be;
    do @(posedge sys_clk_i); while (avs_waitrequest_i !== 1'b0);
    q = avs_readdata_i;
    // released address and write data show the inverse of the last value, not a stale copy
    avs_read_o      <= 1'b0;
    avs_write_o     <= 1'b0;
    avs_address_o   <= ~a;
    avs_writedata_o <= ~d;
  endtask
endmodule // sact_host_model

// [testbench/sact_top_tb.sv]
// self-checking bench for the switch advanced control tail
// assumes sact_host_model drives the register bus of both instances
`timescale 1ns/1ps
`include "sact_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin num_errors++; \
  $display("Error %0t: got %h want %h", $time, g, e); end end

module sact_top_tb;
  // clock, reset and pins
  logic        sys_clk = 1'b0;
  logic        resetn  = 1'b0;
  logic        ce      = 1'b1;
  logic        rmii    = 1'b1;
  logic [9:0]  addr;
  logic        rd_en, wr_en;
  logic [31:0] wdata, rdata, rdata2;
  logic [3:0]  be;
  logic        waitreq, rxc_o, fiber_o, ratio_o;
  logic [1:0]  top_queue_o;
  logic [6:0]  top_rate_o;
  // bookkeeping and shadow of written fields
  int          num_errors = 0, checked = 0, cyc = 0, seed = 56, i;
  logic        fiber_s = 1'b0, inv_s = 1'b0;
  logic [1:0]  mode_s = 2'h0;
  logic [6:0]  rate_s = 7'h0;
  logic [3:0]  s1, s2, s3;
  logic [31:0] q;
  logic [7:0]  idx_tab [9] = '{8'hbf, 8'hcf, 8'hdf, 8'hef, 8'hff, 8'hf0, 8'hf1, 8'hee, 8'h10};

  // free-running clock, 5 ns period
  initial forever #2.5 sys_clk = ~sys_clk;

  // device with the reduced-mii option
  sact_top dut_u (.sys_clk_i(sys_clk), .resetn_i(resetn), .ce_i(ce), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .port5_switch_reduced_mii_i(rmii),
    .switch_port_rx_clock_out_o(rxc_o), .port3_fiber_o(fiber_o), .top_queue_o(top_queue_o),
    .top_rate_o(top_rate_o), .ratio_shaped_o(ratio_o));
  // variant without the option, same bus traffic
  sact_top #(.HAS_RMII_OPTION(1'b0)) dut_norm_u (.sys_clk_i(sys_clk), .resetn_i(resetn), .ce_i(ce),
    .avs_address_i(addr), .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata2), .avs_waitrequest_o(),
    .port5_switch_reduced_mii_i(rmii), .switch_port_rx_clock_out_o(), .port3_fiber_o(),
    .top_queue_o(), .top_rate_o(), .ratio_shaped_o());
  // host master
  sact_host_model host_u (.sys_clk_i(sys_clk), .avs_waitrequest_i(waitreq), .avs_readdata_i(rdata),
    .avs_address_o(addr), .avs_read_o(rd_en), .avs_write_o(wr_en), .avs_writedata_o(wdata),
    .avs_byteenable_o(be));

  // expected read value of an index from the shadow fields
  function automatic logic [31:0] exp_reg(input logic [7:0] idx);
    case (idx)
      8'hbf:   return 32'h80;
      8'hcf:   return 32'h15;
      8'hdf:   return 32'h0c;
      8'hef:   return {24'h0, fiber_s, 7'h0};
      8'hff:   return {27'h0, inv_s, 4'h0};
      8'hf0:   return {24'h0, (mode_s == 2'h1 || mode_s == 2'h2), 5'h0, mode_s};
      8'hf1:   return {25'h0, rate_s};
      default: return 32'h0;
    endcase
  endfunction

  // bus helpers
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [3:0] b = 4'hf,
                    input logic [1:0] lo = 2'h0);
    logic [31:0] t;
    host_u.xfer(1'b1, {idx, lo}, {24'h0, d}, b, t);
  endtask
  task automatic rd(input logic [7:0] idx, output logic [31:0] v);
    host_u.xfer(1'b0, {idx, 2'h0}, 32'h0, 4'hf, v);
  endtask
  // read every mapped index plus two unmapped ones
  task automatic chk_all();
    logic [31:0] v;
    for (int k = 0; k < 9; k++) begin
      rd(idx_tab[k], v);
      `CHK(v, exp_reg(idx_tab[k]))
    end
  endtask
  // rx clock level at each phase of a 4-cycle window
  task automatic phase(output logic [3:0] s);
    repeat (8) @(posedge sys_clk);
    repeat (4) begin
      @(posedge sys_clk);
      s[cyc[1:0]] = rxc_o;
    end
  endtask

  // verdict
  task automatic tally_and_finish();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // cycle count and hang limit
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // main sequence
  initial begin
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    `CHK({fiber_o, top_queue_o, top_rate_o, ratio_o}, 11'h0)
    chk_all();
    // random writes to read-only and unmapped places are ignored
    for (i = 0; i < 9; i++) if (i < 3 || i > 6) wr(idx_tab[i], 8'($random(seed)));
    chk_all();
    // fiber select, other bits of the byte stay zero
    wr(8'hef, 8'hff);
    fiber_s = 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(fiber_o, 1'b1)
    // low byte disabled, then unaligned: both refused
    wr(8'hef, 8'h00, 4'he);
    wr(8'hef, 8'h00, 4'hf, 2'h1);
    repeat (3) @(posedge sys_clk);
    `CHK(fiber_o, 1'b1)
    chk_all();
    wr(8'hef, 8'h00);
    fiber_s = 1'b0;
    repeat (3) @(posedge sys_clk);
    `CHK(fiber_o, 1'b0)
    // every queue mode with a random top rate
    for (i = 0; i < 4; i++) begin
      mode_s = 2'(i);
      rate_s = 7'($random(seed));
      // queue mode set before the rate
      wr(8'hf0, {6'h0, mode_s});
      wr(8'hf1, {1'b0, rate_s});
      repeat (3) @(posedge sys_clk);
      `CHK(top_queue_o, (mode_s == 2'h2) ? 2'h3 : ((mode_s == 2'h1) ? 2'h1 : 2'h0))
      `CHK(top_rate_o, rate_s)
      `CHK(ratio_o, (mode_s == 2'h1 || mode_s == 2'h2))
      chk_all();
    end
    // rx clock: square wave, inverted only in reduced-mii mode
    phase(s1);
    `CHK((s1 == 4'h3 || s1 == 4'h6 || s1 == 4'hc || s1 == 4'h9), 1'b1)
    wr(8'hff, 8'hff);
    inv_s = 1'b1;
    phase(s2);
    `CHK(s2, ~s1)
    rmii <= 1'b0;
    phase(s3);
    `CHK(s3, s1)
    rd(8'hff, q);
    `CHK(q, exp_reg(8'hff))
    `CHK(rdata2, 32'h0)
    // clock enable low: rx clock and pins hold their levels
    wr(8'hef, 8'h80);
    fiber_s = 1'b1;
    repeat (2) @(posedge sys_clk);
    ce <= 1'b0;
    @(posedge sys_clk);
    s1[0] = rxc_o;
    repeat (6) @(posedge sys_clk);
    `CHK({rxc_o, fiber_o, waitreq}, {s1[0], fiber_s, 1'b1})
    ce <= 1'b1;
    // second reset in mid-run: every field back to its default
    resetn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    resetn <= 1'b1;
    {fiber_s, inv_s, mode_s, rate_s} = 11'h000;
    @(posedge sys_clk);
    `CHK({fiber_o, top_queue_o, top_rate_o, ratio_o, waitreq}, 12'h001)
    chk_all();
    tally_and_finish();
  end
endmodule // sact_top_tb
